// file: rtl/rcr_regulator_regs.sv
// Functional notes
// (R1) A set led_open_status bit stays set until the host writes one to it or the bus supply cycles.
// (R2) Enable register bits 2, 1 and 0 turn regulator three, two and one on when one.
// (R3) Regulator one enable resets to one; the other two enables take factory defaults.
// (R4) Config bits 6, 5 and 4 enable output discharge of channels three, two and one, reset zero.
// (R5) Config bits 2, 1 and 0 pick switch mode (one) or regulator mode (zero), reset zero.
// (R6) Voltage select bits 7 to 4 hold the channel two code, reset to a factory value.
// (R7) Bits 3 to 0 hold the channel one code; codes 0 to 15 run from 4.20 V down to 1.00 V.
// (R8) In switch mode a channel's voltage code is not used, yet stays readable and writable.
// (R9) Led_open_status bits 4 to 0 flag open led channels five to one; higher bits are unused.
// (R10) Unused bits read zero and ignore writes.
// (R11) A completed write reaches the control outputs no later than the cycle ending it.
`timescale 1ns/1ps

module rcr_regulator_regs #(
    parameter logic [6:0] I2C_DEVICE_ADDR = 7'h2A, // Bus address, value arbitrary
    parameter logic [1:0] FACTORY_ENABLE_2_3 = 2'h0,
    parameter logic [3:0] FACTORY_VCODE1 = 4'h0,
    parameter logic [3:0] FACTORY_VCODE2 = 4'h0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial host pins, open drain data
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Analog side inputs
    input wire logic bus_supply_input,
    input wire logic [4:0] led_open_detect,
    // Regulator controls
    output logic regulator1_enable,
    output logic regulator2_enable,
    output logic regulator3_enable,
    output logic regulator1_discharge,
    output logic regulator2_discharge,
    output logic regulator3_discharge,
    output logic regulator1_switch_select,
    output logic regulator2_switch_select,
    output logic regulator3_switch_select,
    output logic [3:0] regulator1_voltage_code,
    output logic [3:0] regulator2_voltage_code,
    output logic regulator1_voltage_used,
    output logic regulator2_voltage_used,
    // Status view
    output logic [4:0] led_open_status
);

    typedef struct packed {
        logic [4:0] led;
        logic [2:0] en;
        logic [2:0] dscg;
        logic [2:0] mode;
        logic [7:0] vsel;
        rcr_pkg::rcr_state_e st;
        rcr_pkg::rcr_kind_e kind;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic [7:0] tx;
        logic oe;
        logic scl_q;
        logic sda_q;
    } rcr_regs_s;

    rcr_regs_s state;
    rcr_regs_s next_state;

    logic [2:0] pins_sync;
    logic [4:0] led_sync;
    logic scl_s;
    logic sda_s;
    logic supply_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] byte_in;
    logic [7:0] rdata;

    rcr_sync #(.WIDTH(3)) u_sync_pins (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({scl, sda_in, bus_supply_input}),
        .sync_out(pins_sync)
    );

    rcr_sync #(.WIDTH(5)) u_sync_led (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(led_open_detect),
        .sync_out(led_sync)
    );

    assign scl_s = pins_sync[2];
    assign sda_s = pins_sync[1];
    assign supply_s = pins_sync[0];
    assign scl_rise = scl_s & ~state.scl_q;
    assign scl_fall = ~scl_s & state.scl_q;
    assign start_cond = scl_s & state.scl_q & state.sda_q & ~sda_s;
    assign stop_cond = scl_s & state.scl_q & ~state.sda_q & sda_s;
    assign byte_in = {state.shift[6:0], sda_s};

    // Read view; unmapped addresses and unused bits read zero
    always_comb begin
        rdata = 8'h00;
        unique case (state.ptr)
            rcr_pkg::ADDR_LED_OPEN_STATUS:
                rdata[rcr_pkg::LED_OPEN_LSB +: rcr_pkg::LED_OPEN_W] = state.led; // R9
            rcr_pkg::ADDR_REGULATOR_ENABLE_CONTROL:
                rdata[rcr_pkg::ENABLE_LSB +: rcr_pkg::CHAN_W] = state.en;
            rcr_pkg::ADDR_REGULATOR_MODE_DISCHARGE_CONFIG: begin
                rdata[rcr_pkg::MODE_LSB +: rcr_pkg::CHAN_W] = state.mode;
                rdata[rcr_pkg::DISCHARGE_LSB +: rcr_pkg::CHAN_W] = state.dscg;
            end
            rcr_pkg::ADDR_REGULATOR_VOLTAGE_SELECT:
                rdata = state.vsel;
            default:
                rdata = 8'h00; // R10
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.scl_q = scl_s;
        next_state.sda_q = sda_s;

        // Removing the bus supply wipes the status; a host write of one clears its bit
        if (!supply_s) begin
            next_state.led = '0; // R1
        end

        if (stop_cond) begin
            next_state.st = rcr_pkg::RCR_IDLE;
            next_state.oe = 1'b0;
        end else if (start_cond) begin
            next_state.st = rcr_pkg::RCR_RX;
            next_state.kind = rcr_pkg::RCR_KIND_ADDR;
            next_state.cnt = 3'h0;
            next_state.oe = 1'b0;
        end else begin
            unique case (state.st)
                rcr_pkg::RCR_IDLE: begin
                    next_state.oe = 1'b0;
                end
                rcr_pkg::RCR_RX: begin
                    if (scl_rise) begin
                        next_state.shift = byte_in;
                        next_state.cnt = state.cnt + 3'h1;
                        if (state.cnt == rcr_pkg::BIT_LAST) begin
                            next_state.st = rcr_pkg::RCR_ACK;
                            unique case (state.kind)
                                rcr_pkg::RCR_KIND_ADDR: begin
                                    next_state.rw = byte_in[0];
                                    if (byte_in[7:1] != I2C_DEVICE_ADDR) begin
                                        next_state.st = rcr_pkg::RCR_IDLE;
                                    end
                                end
                                rcr_pkg::RCR_KIND_REG: begin
                                    next_state.ptr = byte_in;
                                end
                                default: begin
                                    // Commit at the last data bit edge
                                    next_state.ptr = state.ptr + 8'h01;
                                    unique case (state.ptr)
                                        rcr_pkg::ADDR_LED_OPEN_STATUS:
                                            next_state.led = next_state.led & ~byte_in[
                                                rcr_pkg::LED_OPEN_LSB +: rcr_pkg::LED_OPEN_W]; // R1
                                        rcr_pkg::ADDR_REGULATOR_ENABLE_CONTROL:
                                            next_state.en = byte_in[
                                                rcr_pkg::ENABLE_LSB +: rcr_pkg::CHAN_W]; // R2 R11
                                        rcr_pkg::ADDR_REGULATOR_MODE_DISCHARGE_CONFIG: begin
                                            next_state.mode = byte_in[
                                                rcr_pkg::MODE_LSB +: rcr_pkg::CHAN_W]; // R5 R11
                                            next_state.dscg = byte_in[
                                                rcr_pkg::DISCHARGE_LSB +: rcr_pkg::CHAN_W]; // R4
                                        end
                                        rcr_pkg::ADDR_REGULATOR_VOLTAGE_SELECT:
                                            next_state.vsel = byte_in; // R6 R7
                                        default:
                                            next_state.vsel = state.vsel; // R10
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                rcr_pkg::RCR_ACK: begin
                    if (scl_fall) begin
                        next_state.oe = 1'b1;
                        next_state.st = rcr_pkg::RCR_ACK_DRV;
                    end
                end
                rcr_pkg::RCR_ACK_DRV: begin
                    if (scl_fall) begin
                        next_state.oe = 1'b0;
                        next_state.cnt = 3'h0;
                        next_state.st = rcr_pkg::RCR_RX;
                        if (state.kind == rcr_pkg::RCR_KIND_ADDR && state.rw) begin
                            next_state.tx = rdata;
                            next_state.ptr = state.ptr + 8'h01;
                            next_state.oe = ~rdata[7];
                            next_state.st = rcr_pkg::RCR_TX;
                        end else if (state.kind == rcr_pkg::RCR_KIND_ADDR) begin
                            next_state.kind = rcr_pkg::RCR_KIND_REG;
                        end else begin
                            next_state.kind = rcr_pkg::RCR_KIND_WDATA;
                        end
                    end
                end
                rcr_pkg::RCR_TX: begin
                    if (scl_rise) begin
                        next_state.cnt = state.cnt + 3'h1;
                        if (state.cnt == rcr_pkg::BIT_LAST) begin
                            next_state.st = rcr_pkg::RCR_TX_END;
                        end
                    end else if (scl_fall) begin
                        next_state.tx = {state.tx[6:0], 1'b0};
                        next_state.oe = ~state.tx[6];
                    end
                end
                rcr_pkg::RCR_TX_END: begin
                    if (scl_fall) begin
                        next_state.oe = 1'b0;
                        next_state.st = rcr_pkg::RCR_TX_ACK;
                    end
                end
                rcr_pkg::RCR_TX_ACK: begin
                    if (scl_rise) begin
                        next_state.st = sda_s ? rcr_pkg::RCR_IDLE : rcr_pkg::RCR_TX_LOAD;
                    end
                end
                rcr_pkg::RCR_TX_LOAD: begin
                    if (scl_fall) begin
                        next_state.tx = rdata;
                        next_state.ptr = state.ptr + 8'h01;
                        next_state.oe = ~rdata[7];
                        next_state.cnt = 3'h0;
                        next_state.st = rcr_pkg::RCR_TX;
                    end
                end
            endcase
        end

        // A newly detected open channel wins over any clear in the same cycle
        next_state.led = next_state.led | led_sync; // R1 R9
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.led <= rcr_pkg::LED_OPEN_RESET;
            state.en <= {FACTORY_ENABLE_2_3, rcr_pkg::REGULATOR1_ENABLE_RESET}; // R3
            state.dscg <= rcr_pkg::DISCHARGE_RESET; // R4
            state.mode <= rcr_pkg::MODE_RESET; // R5
            state.vsel <= {FACTORY_VCODE2, FACTORY_VCODE1}; // R6
            state.st <= rcr_pkg::RCR_IDLE;
            state.kind <= rcr_pkg::RCR_KIND_ADDR;
            state.scl_q <= 1'b1;
            state.sda_q <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = state.oe;
    assign regulator1_enable = state.en[0]; // R2
    assign regulator2_enable = state.en[1];
    assign regulator3_enable = state.en[2];
    assign regulator1_discharge = state.dscg[0]; // R4
    assign regulator2_discharge = state.dscg[1];
    assign regulator3_discharge = state.dscg[2];
    assign regulator1_switch_select = state.mode[0]; // R5
    assign regulator2_switch_select = state.mode[1];
    assign regulator3_switch_select = state.mode[2];
    assign regulator1_voltage_code = state.vsel[rcr_pkg::VCODE1_LSB +: rcr_pkg::VCODE_W]; // R7
    assign regulator2_voltage_code = state.vsel[rcr_pkg::VCODE2_LSB +: rcr_pkg::VCODE_W]; // R6
    assign regulator1_voltage_used = ~state.mode[0]; // R8
    assign regulator2_voltage_used = ~state.mode[1]; // R8
    assign led_open_status = state.led;

endmodule // rcr_regulator_regs

// file: rtl/rcr_pkg.sv
package rcr_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_LED_OPEN_STATUS = 8'h31;
    localparam logic [7:0] ADDR_REGULATOR_ENABLE_CONTROL = 8'h32;
    localparam logic [7:0] ADDR_REGULATOR_MODE_DISCHARGE_CONFIG = 8'h33;
    localparam logic [7:0] ADDR_REGULATOR_VOLTAGE_SELECT = 8'h34;

    // Field positions
    localparam int LED_OPEN_LSB = 0;
    localparam int LED_OPEN_W = 5;
    localparam int ENABLE_LSB = 0;
    localparam int CHAN_W = 3;
    localparam int MODE_LSB = 0;
    localparam int DISCHARGE_LSB = 4;
    localparam int VCODE1_LSB = 0;
    localparam int VCODE2_LSB = 4;
    localparam int VCODE_W = 4;

    // Values after reset
    localparam logic [4:0] LED_OPEN_RESET = 5'h00;
    localparam logic [0:0] REGULATOR1_ENABLE_RESET = 1'h1;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] DISCHARGE_RESET = 3'h0;

    // Serial interface
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        RCR_IDLE,
        RCR_RX,
        RCR_ACK,
        RCR_ACK_DRV,
        RCR_TX,
        RCR_TX_END,
        RCR_TX_ACK,
        RCR_TX_LOAD
    } rcr_state_e;

    typedef enum logic [1:0] {
        RCR_KIND_ADDR,
        RCR_KIND_REG,
        RCR_KIND_WDATA
    } rcr_kind_e;

endpackage

// file: rtl/rcr_sync.sv
`timescale 1ns/1ps

module rcr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } rcr_sync_s;

    rcr_sync_s state;
    rcr_sync_s next_state;

    always_comb begin
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule // rcr_sync

// file: tb/rcr_regs_properties.sv
`timescale 1ns/1ps

module rcr_regs_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial pins
    input wire logic scl,
    input wire logic sda_oe,
    // Analog side
    input wire logic bus_supply_input,
    input wire logic [4:0] led_open_detect,
    input wire logic [4:0] led_open_status,
    // Controls
    input wire logic regulator1_enable,
    input wire logic regulator2_enable,
    input wire logic regulator3_enable,
    input wire logic regulator1_switch_select,
    input wire logic regulator2_switch_select,
    input wire logic regulator3_switch_select,
    input wire logic regulator1_voltage_used,
    input wire logic regulator2_voltage_used
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [2:0] ens = {regulator3_enable, regulator2_enable, regulator1_enable};
    wire [2:0] sws = {regulator3_switch_select, regulator2_switch_select, regulator1_switch_select};

    reset_values_a: assert property (
        $rose(rst_n) |-> ens[0] && sws == 3'h0) else $error("control value wrong after reset");
    used_one_a: assert property (
        !$changed(sws[0]) |-> regulator1_voltage_used != sws[0]) else $error("code use one wrong");
    used_two_a: assert property (
        !$changed(sws[1]) |-> regulator2_voltage_used != sws[1]) else $error("code use two wrong");
    status_hold_a: assert property (
        |($past(led_open_status) & ~led_open_status) |-> scl || !$past(bus_supply_input, 2)
        || !$past(bus_supply_input, 3) || !$past(bus_supply_input, 4))
        else $error("status bit dropped without cause");
    led_set_a: assert property (
        $past(rst_n, 3) && $past(rst_n) |-> ((led_open_detect & $past(led_open_detect)
        & $past(led_open_detect, 2) & $past(led_open_detect, 3)) & ~led_open_status) == 5'h00)
        else $error("open led not flagged");
    led_rise_a: assert property (
        ((led_open_status & ~$past(led_open_status)) & ~$past(led_open_detect, 3)) == 5'h00)
        else $error("status bit set without open led");
    ctrl_change_a: assert property (
        $changed({ens, sws}) |-> scl) else $error("control changed outside a bit time");
    oe_timing_a: assert property (
        $changed(sda_oe) |-> !scl && !$past(scl)) else $error("data drive changed with clock high");

    cover property ($rose(sda_oe));
    cover property ($fell(led_open_status[0]));
    cover property ($fell(regulator1_voltage_used));
endmodule // rcr_regs_properties

bind rcr_regulator_regs rcr_regs_properties u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_oe(sda_oe),
    .bus_supply_input(bus_supply_input), .led_open_detect(led_open_detect),
    .led_open_status(led_open_status), .regulator1_enable(regulator1_enable),
    .regulator2_enable(regulator2_enable), .regulator3_enable(regulator3_enable),
    .regulator1_switch_select(regulator1_switch_select),
    .regulator2_switch_select(regulator2_switch_select),
    .regulator3_switch_select(regulator3_switch_select),
    .regulator1_voltage_used(regulator1_voltage_used),
    .regulator2_voltage_used(regulator2_voltage_used)
);

// file: tb/rcr_host_model.sv
`timescale 1ns/1ps

module rcr_host_model (
    // Clock
    input wire logic clk_sys,
    // Bus lines
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Data moves only with the clock low, so it never reads as a start or stop
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_low <= !b;
        w(8);
        scl <= 1'b1;
        w(10);
        r = sda_line;
        scl <= 1'b0;
    endtask

    task automatic start();
        w(2);
        sda_low <= 1'b0;
        w(8);
        scl <= 1'b1;
        w(10);
        sda_low <= 1'b1;
        w(10);
        scl <= 1'b0;
    endtask

    task automatic stop();
        w(2);
        sda_low <= 1'b1;
        w(8);
        scl <= 1'b1;
        w(10);
        sda_low <= 1'b0;
        w(10);
    endtask

    task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q = {q[6:0], r};
        end
        bit_x(nack, r);
        ack = !r;
    endtask
endmodule // rcr_host_model

// file: tb/regulator_control_registers_test.sv
`timescale 1ns/1ps

module regulator_control_registers_test;
    logic clk_sys, rst_n, bus_supply_input, sda_out, sda_oe, scl, sda_low;
    logic [4:0] led_open_detect, led_open_status;
    logic [2:0] en, dis, sw;
    logic [3:0] vc1, vc2;
    logic [1:0] used;
    int error_cnt, num_checks;
    // Open drain line with pull-up
    wire sda_line = !(sda_low || (sda_oe && !sda_out));

    rcr_regulator_regs DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .bus_supply_input(bus_supply_input),
        .led_open_detect(led_open_detect), .regulator1_enable(en[0]),
        .regulator2_enable(en[1]), .regulator3_enable(en[2]),
        .regulator1_discharge(dis[0]), .regulator2_discharge(dis[1]),
        .regulator3_discharge(dis[2]), .regulator1_switch_select(sw[0]),
        .regulator2_switch_select(sw[1]), .regulator3_switch_select(sw[2]),
        .regulator1_voltage_code(vc1), .regulator2_voltage_code(vc2),
        .regulator1_voltage_used(used[0]), .regulator2_voltage_used(used[1]),
        .led_open_status(led_open_status)
    );

    rcr_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic k;
        host.start();
        host.xfer(8'h54, 1'b1, q, k);
        host.xfer(a, 1'b1, q, k);
        host.xfer(d, 1'b1, q, k);
        host.stop();
        chk("write ack", 8'h01, {7'h00, k});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic k;
        host.start();
        host.xfer(8'h54, 1'b1, q, k);
        host.xfer(a, 1'b1, q, k);
        host.start();
        host.xfer(8'h55, 1'b1, q, k);
        host.xfer(8'hFF, 1'b1, q, k);
        host.stop();
        chk("read data", e, q);
    endtask

    task automatic t_reset();
        chk("enables", 8'h01, {5'h00, en});
        chk("discharge mode", 8'h00, {1'b0, dis, 1'b0, sw});
        chk("codes", 8'h00, {vc2, vc1});
        rd(8'h32, 8'h01);
        rd(8'h33, 8'h00);
        rd(8'h34, 8'h00);
        rd(8'h40, 8'h00);
    endtask

    task automatic t_ctrl();
        wr(8'h32, 8'hFA);
        chk("enables", 8'h02, {5'h00, en});
        rd(8'h32, 8'h02);
        wr(8'h32, 8'h05);
        chk("enables", 8'h05, {5'h00, en});
        wr(8'h33, 8'hA5);
        chk("discharge mode", 8'h25, {1'b0, dis, 1'b0, sw});
        chk("code use", 8'h02, {6'h00, used});
        rd(8'h33, 8'h25);
        wr(8'h33, 8'h5A);
        chk("discharge mode", 8'h52, {1'b0, dis, 1'b0, sw});
        chk("code use", 8'h01, {6'h00, used});
    endtask

    task automatic t_vsel();
        wr(8'h34, 8'h9F);
        chk("codes", 8'h9F, {vc2, vc1});
        rd(8'h34, 8'h9F);
        wr(8'h34, 8'h60);
        chk("codes", 8'h60, {vc2, vc1});
    endtask

    // Foreign address ignored, then pointer auto-increment on write and read
    task automatic t_burst();
        logic [7:0] q;
        logic k;
        host.start();
        host.xfer(8'h56, 1'b1, q, k);
        chk("foreign ack", 8'h00, {7'h00, k});
        host.xfer(8'h32, 1'b1, q, k);
        host.xfer(8'h00, 1'b1, q, k);
        host.stop();
        chk("enables", 8'h05, {5'h00, en});
        host.start();
        host.xfer(8'h54, 1'b1, q, k);
        host.xfer(8'h32, 1'b1, q, k);
        host.xfer(8'h02, 1'b1, q, k);
        host.xfer(8'h10, 1'b1, q, k);
        host.stop();
        chk("burst ack", 8'h01, {7'h00, k});
        chk("enables", 8'h02, {5'h00, en});
        chk("discharge mode", 8'h10, {1'b0, dis, 1'b0, sw});
        host.start();
        host.xfer(8'h54, 1'b1, q, k);
        host.xfer(8'h32, 1'b1, q, k);
        host.start();
        host.xfer(8'h55, 1'b1, q, k);
        host.xfer(8'hFF, 1'b0, q, k);
        chk("burst read", 8'h02, q);
        host.xfer(8'hFF, 1'b1, q, k);
        host.stop();
        chk("burst read", 8'h10, q);
    endtask

    task automatic t_led();
        led_open_detect <= 5'h15;
        repeat (5) @(posedge clk_sys);
        led_open_detect <= 5'h00;
        repeat (5) @(posedge clk_sys);
        chk("led_open_status", 8'h15, {3'h0, led_open_status});
        rd(8'h31, 8'h15);
        wr(8'h31, 8'hE1);
        rd(8'h31, 8'h14);
        bus_supply_input <= 1'b0;
        repeat (5) @(posedge clk_sys);
        bus_supply_input <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("led_open_status", 8'h00, {3'h0, led_open_status});
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        bus_supply_input = 1'b1;
        led_open_detect = 5'h00;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_ctrl();
        t_vsel();
        t_burst();
        t_led();
        finish_test();
    end
endmodule // regulator_control_registers_test
